/* src/rbf_rx_buffer.sv */
`timescale 1ns/1ps
// Overview of operation
// - Software reads status and ninth bit before data.
// - Data read advances buffer; flags follow next entry.
// - Complete flag high exactly while unread data exists.
// - Receiver disable flushes all buffered entries.
// - Level interrupt while enable and complete flag set.
// - Handler must read data to drop request.
// - Error flags stored with their frame's entry.
// - Error flag bits ignore software writes.
// - Software writes zeros into error flag positions.
// - Error flags never raise an interrupt.
// - Frame error equals inverted first stop bit.
// - Only the first stop bit is checked.
// - Overrun: buffer full, frame waiting, new start.
// - Overrun clears on successful transfer into buffer.
// - Parity checked only when enabled; odd/even select.
// - Parity error kept per entry, zero when unchecked.
// - Disable is immediate; frame discarded, pin released.
// - Flush by reading data until flag clears.
// - Complete frame moves into buffer after stop bit.
// - Unused upper data bits read as zero.
// - Enable activates reception and takes the pin.
module rbf_rx_buffer
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clkEn,
  rbf_link_if.devEnd link,
  input wire logic frameValid,
  input wire logic [8:0] frameData,
  input wire logic frameParity,
  input wire logic frameStop,
  input wire logic startDetect,
  output logic frameDiscard,
  output logic rxPinOverride
);
  logic [7:0] control_q; // Writable control bits.
  logic [7:0] format_q; // Frame format bits.
  logic [11:0] bufMem [0:1]; // Two-entry receive buffer.
  logic wrPtr_q; // Next slot to fill.
  logic rdPtr_q; // Slot presented to software.
  logic [1:0] count_q; // Unread entries.
  logic pendValid_q; // A finished frame waits in the shift register.
  logic [11:0] pendEntry_q; // That frame with its flags.
  logic overrun_q; // Frames were lost since the last transfer.
  logic [7:0] rdata_q; // Read answer.
  logic rvalid_q; // Read answer strobe.
  logic irq_q; // Receive-complete request.
  logic discard_q; // One-cycle pulse on receiver disable.
  logic [11:0] checked; // Entry built from the incoming frame.
  logic [11:0] head; // Entry at the read position.
  logic receiver_enable; // Receiver enable.
  logic flush; // Software is clearing the receiver enable.
  logic pop; // Software reads the data location.
  logic push; // Waiting frame moves into the buffer.
  logic full; // Buffer holds two entries.
  logic [2:0] sizeCode; // Character size code.
  logic [7:0] statusView; // Assembled status register.
  logic [11:0] pushEntry; // Entry written on push, with overrun.

  assign receiver_enable = control_q[rbf_pkg::CTRL_RECEIVER_ENABLE_BIT];
  assign sizeCode = {control_q[rbf_pkg::CTRL_SIZE2_BIT],
    format_q[rbf_pkg::FMT_SIZE_HI_BIT], format_q[rbf_pkg::FMT_SIZE_LO_BIT]};
  assign head = bufMem[rdPtr_q];
  assign full = (count_q == rbf_pkg::BUF_DEPTH);
  assign flush = link.regWr && (link.regAddr == rbf_pkg::CONTROL_ADDR) &&
    !link.regWdata[rbf_pkg::CTRL_RECEIVER_ENABLE_BIT];
  assign pop = link.regRd && (link.regAddr == rbf_pkg::DATA_ADDR) &&
    (count_q != 2'h0);
  // A waiting frame moves in when a slot is free or freed this cycle.
  assign push = pendValid_q && (!full || pop) && receiver_enable && !flush;

  // Outputs all come straight from flip-flops.
  assign link.regRdata = rdata_q;
  assign link.regRvalid = rvalid_q;
  assign link.rxcIrq = irq_q;
  assign frameDiscard = discard_q;
  assign rxPinOverride = control_q[rbf_pkg::CTRL_RECEIVER_ENABLE_BIT];

  // Entry builder: data masking, stop-bit and parity checks.
  rbf_frame_check u_check
  (
    .frameData(frameData),
    .frameParity(frameParity),
    .frameStop(frameStop),
    .sizeCode(sizeCode),
    .parEn(format_q[rbf_pkg::FMT_PAR_EN_BIT]),
    .parOdd(format_q[rbf_pkg::FMT_PAR_ODD_BIT]),
    .entry(checked)
  );

  // The overrun indication travels with the frame that follows the loss.
  always_comb
  begin
    pushEntry = pendEntry_q;
    pushEntry[rbf_pkg::ENT_DOR_BIT] = overrun_q;
  end

  // Status view; flags are those of the entry at the read position.
  always_comb
  begin
    statusView = 8'h00;
    statusView[rbf_pkg::STAT_RXC_BIT] = (count_q != 2'h0);
    if (count_q != 2'h0)
    begin
      statusView[rbf_pkg::STAT_FE_BIT] = head[rbf_pkg::ENT_FE_BIT];
      statusView[rbf_pkg::STAT_DOR_BIT] = head[rbf_pkg::ENT_DOR_BIT];
      statusView[rbf_pkg::STAT_UPE_BIT] = head[rbf_pkg::ENT_UPE_BIT];
    end
  end

  // Control and format registers. The status register has no
  // writable bits, so a write there changes nothing.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      control_q <= rbf_pkg::CONTROL_RESET;
      format_q <= rbf_pkg::FORMAT_RESET;
    end
    else if (clkEn && link.regWr)
    begin
      // Error flags live only in the buffer; writes never reach them.
      if (link.regAddr == rbf_pkg::CONTROL_ADDR)
      begin
        control_q <= link.regWdata & rbf_pkg::CTRL_WR_MASK;
      end
      else if (link.regAddr == rbf_pkg::FORMAT_ADDR)
      begin
        format_q <= link.regWdata & rbf_pkg::FORMAT_WR_MASK;
      end
    end
  end

  // Shift-register holding slot. A frame that finds the buffer full
  // waits here; a later frame overwrites it, which is the loss case.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pendValid_q <= 1'b0;
      pendEntry_q <= '0;
    end
    else if (clkEn)
    begin
      if (flush || !receiver_enable)
      begin
        pendValid_q <= 1'b0;
      end
      else if (frameValid)
      begin
        pendValid_q <= 1'b1;
        pendEntry_q <= checked;
      end
      else if (push)
      begin
        pendValid_q <= 1'b0;
      end
    end
  end

  // Overrun tracking. Set and clear cannot coincide: a push needs a
  // free slot, and the set needs a full buffer with no read.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      overrun_q <= 1'b0;
    end
    else if (clkEn)
    begin
      if (flush || !receiver_enable)
      begin
        overrun_q <= 1'b0;
      end
      else if (push)
      begin
        overrun_q <= 1'b0;
      end
      else if (startDetect && pendValid_q && full && !pop)
      begin
        overrun_q <= 1'b1;
      end
    end
  end

  // Buffer storage. No reset is needed: count_q guards every read.
  always_ff @(posedge clk_sys)
  begin
    if (clkEn && push)
    begin
      bufMem[wrPtr_q] <= pushEntry;
    end
  end

  // Pointers and fill level.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      count_q <= 2'h0;
    end
    else if (clkEn)
    begin
      if (flush || !receiver_enable)
      begin
        // Unread data is thrown away when the receiver is disabled.
        wrPtr_q <= 1'b0;
        rdPtr_q <= 1'b0;
        count_q <= 2'h0;
      end
      else
      begin
        if (push)
        begin
          wrPtr_q <= ~wrPtr_q;
        end
        if (pop)
        begin
          rdPtr_q <= ~rdPtr_q;
        end
        if (push && !pop)
        begin
          count_q <= count_q + 2'h1;
        end
        else if (pop && !push)
        begin
          count_q <= count_q - 2'h1;
        end
      end
    end
  end

  // Read answers, one cycle after the strobe.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else if (clkEn)
    begin
      rvalid_q <= link.regRd;
      if (link.regRd)
      begin
        case (link.regAddr)
          rbf_pkg::STATUS_ADDR: rdata_q <= statusView;
          rbf_pkg::CONTROL_ADDR:
          begin
            rdata_q <= control_q;
            rdata_q[rbf_pkg::CTRL_RECEIVED_NINTH_BIT_BIT] <= (count_q != 2'h0) &&
              head[8];
          end
          rbf_pkg::FORMAT_ADDR: rdata_q <= format_q;
          rbf_pkg::DATA_ADDR:
            rdata_q <= (count_q != 2'h0) ? head[7:0] : 8'h00;
          default: rdata_q <= 8'h00;
        endcase
      end
    end
  end

  // Interrupt request: a level that follows the complete flag, with
  // no contribution from any error flag.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_q <= 1'b0;
    end
    else if (clkEn)
    begin
      irq_q <= control_q[rbf_pkg::CTRL_RECEIVE_COMPLETE_IRQ_ENABLE_BIT] &&
        (count_q != 2'h0);
    end
  end

  // Tell the bit sampler to drop any frame in progress on disable.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      discard_q <= 1'b0;
    end
    else if (clkEn)
    begin
      discard_q <= flush;
    end
  end
endmodule

/* src/rbf_pkg.sv */
package rbf_pkg;

  // Register addresses on the link's register port.
  localparam int ADDR_W = 2;
  localparam logic [1:0] STATUS_ADDR = 2'h0;
  localparam logic [1:0] CONTROL_ADDR = 2'h1;
  localparam logic [1:0] FORMAT_ADDR = 2'h2;
  localparam logic [1:0] DATA_ADDR = 2'h3;

  // Status register bit positions.
  localparam int STAT_RXC_BIT = 7;
  localparam int STAT_FE_BIT = 4;
  localparam int STAT_DOR_BIT = 3;
  localparam int STAT_UPE_BIT = 2;
  localparam logic [7:0] STAT_ERR_MASK = 8'h1C;

  // Control register bit positions.
  localparam int CTRL_RECEIVE_COMPLETE_IRQ_ENABLE_BIT = 7;
  localparam int CTRL_RECEIVER_ENABLE_BIT = 4;
  localparam int CTRL_SIZE2_BIT = 2;
  localparam int CTRL_RECEIVED_NINTH_BIT_BIT = 1;
  localparam int CTRL_NINTH_BIT_FIELD_BIT = 0;
  localparam logic [7:0] CTRL_WR_MASK = 8'h95;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // Format register bit positions.
  localparam int FMT_PAR_EN_BIT = 5;
  localparam int FMT_PAR_ODD_BIT = 4;
  localparam int FMT_STOP_BIT = 3;
  localparam int FMT_SIZE_HI_BIT = 2;
  localparam int FMT_SIZE_LO_BIT = 1;
  localparam logic [7:0] FORMAT_WR_MASK = 8'h3E;
  localparam logic [7:0] FORMAT_RESET = 8'h06;

  // Buffer entry layout: nine data bits, then the three error flags.
  localparam int DATA_W = 9;
  localparam int ENT_W = 12;
  localparam int ENT_FE_BIT = 9;
  localparam int ENT_DOR_BIT = 10;
  localparam int ENT_UPE_BIT = 11;
  localparam logic [1:0] BUF_DEPTH = 2'h2;

  // Host sequencer states, one-hot.
  typedef enum logic [6:0]
  {
    H_IDLE = 7'h01,
    H_RSTAT = 7'h02,
    H_RCTRL = 7'h04,
    H_RDATA = 7'h08,
    H_DONE = 7'h10,
    H_FCHK = 7'h20,
    H_WRITE = 7'h40
  } rbf_hstate_t;

  // Mask of valid data bits for a character size code.
  function automatic logic [8:0] sizeMask(input logic [2:0] size);
    case (size)
      3'h0: sizeMask = 9'h01F;
      3'h1: sizeMask = 9'h03F;
      3'h2: sizeMask = 9'h07F;
      3'h3: sizeMask = 9'h0FF;
      3'h7: sizeMask = 9'h1FF;
      default: sizeMask = 9'h0FF;
    endcase
  endfunction

endpackage

/* src/rbf_link_if.sv */
`timescale 1ns/1ps
// Register port between the receive buffer and the party reading it.
interface rbf_link_if;
  logic [1:0] regAddr; // Register address.
  logic regRd; // Read strobe, one cycle.
  logic regWr; // Write strobe, one cycle.
  logic [7:0] regWdata; // Write data.
  logic [7:0] regRdata; // Read data, valid with regRvalid.
  logic regRvalid; // Read answer, one cycle after regRd.
  logic rxcIrq; // Receive-complete request, level.

  modport devEnd
  (
    input regAddr,
    input regRd,
    input regWr,
    input regWdata,
    output regRdata,
    output regRvalid,
    output rxcIrq
  );

  modport hostEnd
  (
    output regAddr,
    output regRd,
    output regWr,
    output regWdata,
    input regRdata,
    input regRvalid,
    input rxcIrq
  );
endinterface

/* src/rbf_frame_check.sv */
`timescale 1ns/1ps
// Builds one buffer entry from a frame leaving the shift register.
module rbf_frame_check
(
  input wire logic [8:0] frameData,
  input wire logic frameParity,
  input wire logic frameStop,
  input wire logic [2:0] sizeCode,
  input wire logic parEn,
  input wire logic parOdd,
  output logic [11:0] entry
);
  logic [8:0] dataMasked; // Unused upper bits forced to zero.
  logic parErr; // Parity mismatch while checking is on.

  // Parity is taken over the bits that belong to the character only.
  always_comb
  begin
    dataMasked = frameData & rbf_pkg::sizeMask(sizeCode);
    parErr = parEn & (((^dataMasked) ^ parOdd) != frameParity);
    entry = '0;
    entry[8:0] = dataMasked;
    entry[rbf_pkg::ENT_FE_BIT] = ~frameStop;
    entry[rbf_pkg::ENT_UPE_BIT] = parErr;
  end
endmodule

/* src/rbf_reg_host.sv */
`timescale 1ns/1ps
// Register-reading end: fetches characters in the safe order,
// flushes the buffer, and passes writes on.
module rbf_reg_host
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clkEn,
  rbf_link_if.hostEnd link,
  input wire logic cmdFetch,
  input wire logic cmdFlush,
  input wire logic cmdWrite,
  input wire logic [1:0] cmdAddr,
  input wire logic [7:0] cmdData,
  input wire logic globalIrqEn,
  output logic busy,
  output logic fetchValid,
  output logic [8:0] fetchData,
  output logic [2:0] fetchErr,
  output logic irqPending
);
  rbf_pkg::rbf_hstate_t state_q; // Sequencer state.
  logic [1:0] addr_q; // Driven register address.
  logic rd_q; // Driven read strobe.
  logic wr_q; // Driven write strobe.
  logic [7:0] wdata_q; // Driven write data.
  logic [7:0] status_q; // Captured status.
  logic ninth_q; // Captured ninth bit.
  logic valid_q; // Fetch result strobe.
  logic [8:0] data_q; // Fetch result data.
  logic [2:0] err_q; // Fetch result flags: frame, overrun, parity.
  logic irq_q; // Gated interrupt request.

  assign link.regAddr = addr_q;
  assign link.regRd = rd_q;
  assign link.regWr = wr_q;
  assign link.regWdata = wdata_q;
  assign busy = (state_q != rbf_pkg::H_IDLE);
  assign fetchValid = valid_q;
  assign fetchData = data_q;
  assign fetchErr = err_q;
  assign irqPending = irq_q;

  // Sequencer. Status and ninth bit are read before data, because the
  // data read moves the buffer on and their values with it.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= rbf_pkg::H_IDLE;
      addr_q <= rbf_pkg::STATUS_ADDR;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      wdata_q <= 8'h00;
    end
    else if (clkEn)
    begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      case (state_q)
        rbf_pkg::H_IDLE:
        begin
          if (cmdWrite)
          begin
            addr_q <= cmdAddr;
            wr_q <= 1'b1;
            // Error flag positions are always written as zero.
            wdata_q <= (cmdAddr == rbf_pkg::STATUS_ADDR) ?
              (cmdData & ~rbf_pkg::STAT_ERR_MASK) : cmdData;
            state_q <= rbf_pkg::H_WRITE;
          end
          else if (cmdFetch || cmdFlush)
          begin
            addr_q <= rbf_pkg::STATUS_ADDR;
            rd_q <= 1'b1;
            state_q <= cmdFetch ? rbf_pkg::H_RSTAT : rbf_pkg::H_FCHK;
          end
        end
        rbf_pkg::H_RSTAT:
        begin
          addr_q <= rbf_pkg::CONTROL_ADDR;
          rd_q <= 1'b1;
          state_q <= rbf_pkg::H_RCTRL;
        end
        rbf_pkg::H_RCTRL:
        begin
          // Reading data is what lowers the flag and the request.
          addr_q <= rbf_pkg::DATA_ADDR;
          rd_q <= 1'b1;
          state_q <= rbf_pkg::H_RDATA;
        end
        rbf_pkg::H_RDATA: state_q <= rbf_pkg::H_DONE;
        rbf_pkg::H_DONE: state_q <= rbf_pkg::H_IDLE;
        rbf_pkg::H_FCHK:
        begin
          // With a read still in flight the answer is the data byte,
          // not the status, so it must not decide the flush.
          if (link.regRvalid && !rd_q)
          begin
            if (link.regRdata[rbf_pkg::STAT_RXC_BIT])
            begin
              addr_q <= rbf_pkg::DATA_ADDR;
              rd_q <= 1'b1;
              state_q <= rbf_pkg::H_WRITE;
            end
            else
            begin
              state_q <= rbf_pkg::H_IDLE;
            end
          end
        end
        rbf_pkg::H_WRITE:
        begin
          // After a flush data read, check the flag again.
          if (addr_q == rbf_pkg::DATA_ADDR && !wr_q && !busyWrite(wr_q))
          begin
            addr_q <= rbf_pkg::STATUS_ADDR;
            rd_q <= 1'b1;
            state_q <= rbf_pkg::H_FCHK;
          end
          else
          begin
            state_q <= rbf_pkg::H_IDLE;
          end
        end
        default: state_q <= rbf_pkg::H_IDLE;
      endcase
    end
  end

  // True when the previous cycle issued a write rather than a read.
  function automatic logic busyWrite(input logic wr);
    busyWrite = wr;
  endfunction

  // Capture of read answers and the fetch result.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_q <= 8'h00;
      ninth_q <= 1'b0;
      valid_q <= 1'b0;
      data_q <= 9'h000;
      err_q <= 3'h0;
    end
    else if (clkEn)
    begin
      valid_q <= 1'b0;
      if (state_q == rbf_pkg::H_RCTRL)
      begin
        status_q <= link.regRdata;
      end
      if (state_q == rbf_pkg::H_RDATA)
      begin
        ninth_q <= link.regRdata[rbf_pkg::CTRL_RECEIVED_NINTH_BIT_BIT];
      end
      if (state_q == rbf_pkg::H_DONE)
      begin
        valid_q <= 1'b1;
        data_q <= {ninth_q, link.regRdata};
        err_q <= {status_q[rbf_pkg::STAT_FE_BIT],
          status_q[rbf_pkg::STAT_DOR_BIT], status_q[rbf_pkg::STAT_UPE_BIT]};
      end
    end
  end

  // The device request is gated by the global interrupt enable.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_q <= 1'b0;
    end
    else if (clkEn)
    begin
      irq_q <= globalIrqEn && link.rxcIrq;
    end
  end
endmodule

/* test/rbf_link_sva.sv */
`timescale 1ns/1ps
// Watches the register port that joins the two ends of the buffer.
module rbf_link_sva
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [1:0] regAddr,
  input wire logic regRd,
  input wire logic regWr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic regRvalid,
  input wire logic rxcIrq
);
  logic [1:0] rdAddrQ; // Address of the read now being answered.
  logic [7:0] ctrlQ; // Shadow of the control register.
  logic rxcSeenQ; // Last receive-complete bit seen in a status answer.

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // Keep the read address, since the answer comes a cycle later.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rdAddrQ <= rbf_pkg::STATUS_ADDR;
    else if (regRd)
      rdAddrQ <= regAddr;
  end

  // Shadow the control register from the write strobes.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ctrlQ <= rbf_pkg::CONTROL_RESET;
    else if (regWr && regAddr == rbf_pkg::CONTROL_ADDR)
      ctrlQ <= regWdata;
  end

  // Remember whether the last status answer showed unread data.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rxcSeenQ <= 1'b0;
    else if (regRvalid && rdAddrQ == rbf_pkg::STATUS_ADDR)
      rxcSeenQ <= regRdata[rbf_pkg::STAT_RXC_BIT];
  end

  a_read_gets_answer: assert property (regRd |=> regRvalid)
    else $error("read strobe got no answer");
  a_answer_has_read: assert property (regRvalid |-> $past(regRd))
    else $error("answer without a read");
  a_ctrl_reads_back: assert property (regRvalid &&
    rdAddrQ == rbf_pkg::CONTROL_ADDR |-> (regRdata & rbf_pkg::CTRL_WR_MASK)
    == (ctrlQ & rbf_pkg::CTRL_WR_MASK))
    else $error("control readback differs");
  a_empty_flags_zero: assert property (regRvalid &&
    rdAddrQ == rbf_pkg::STATUS_ADDR && !regRdata[rbf_pkg::STAT_RXC_BIT]
    |-> (regRdata & rbf_pkg::STAT_ERR_MASK) == 8'h00)
    else $error("error flags set while empty");
  a_empty_data_zero: assert property (regRvalid &&
    rdAddrQ == rbf_pkg::DATA_ADDR && !rxcSeenQ |-> regRdata == 8'h00)
    else $error("empty data read not zero");
  a_irq_needs_en: assert property (rxcIrq |->
    $past(ctrlQ[rbf_pkg::CTRL_RECEIVE_COMPLETE_IRQ_ENABLE_BIT]))
    else $error("request while interrupt disabled");
  a_rxc_gives_irq: assert property (regRvalid &&
    rdAddrQ == rbf_pkg::STATUS_ADDR && regRdata[rbf_pkg::STAT_RXC_BIT] &&
    ctrlQ[rbf_pkg::CTRL_RECEIVE_COMPLETE_IRQ_ENABLE_BIT] && $past(ctrlQ[rbf_pkg::CTRL_RECEIVE_COMPLETE_IRQ_ENABLE_BIT], 2)
    |-> ##[0:1] rxcIrq)
    else $error("unread data but no request");
  a_disable_drops_irq: assert property (regWr &&
    regAddr == rbf_pkg::CONTROL_ADDR && !regWdata[rbf_pkg::CTRL_RECEIVER_ENABLE_BIT]
    |-> ##[1:4] !rxcIrq)
    else $error("request kept after disable");
  a_status_wr_clean: assert property (regWr &&
    regAddr == rbf_pkg::STATUS_ADDR |-> (regWdata & rbf_pkg::STAT_ERR_MASK)
    == 8'h00)
    else $error("status write carries flag bits");
endmodule

/* test/tb_uart_receive_buffer_flags.sv */
`timescale 1ns/1ps
// Drives the host end by commands and the frame side by strobes.
module tb_uart_receive_buffer_flags;
  logic clk_sys; // System clock.
  logic rst_n; // Reset, active low.
  logic frameValid, frameParity, frameStop, startDetect; // Frame side.
  logic [8:0] frameData; // Raw received bits.
  logic cmdFetch, cmdFlush, cmdWrite, globalIrqEn; // Host commands.
  logic [1:0] cmdAddr;
  logic [7:0] cmdData;
  logic busy, fetchValid, irqPending, frameDiscard, rxPinOverride;
  logic [8:0] fetchData;
  logic [2:0] fetchErr;
  logic [2:0] code; // Character size code under test.
  int errTotal;
  int checked;
  int discards; // Discard pulses seen.

  rbf_link_if link();
  rbf_rx_buffer i_rbf_rx_buffer(.clk_sys(clk_sys), .rst_n(rst_n),
    .clkEn(1'b1), .link(link.devEnd), .frameValid(frameValid),
    .frameData(frameData), .frameParity(frameParity), .frameStop(frameStop),
    .startDetect(startDetect), .frameDiscard(frameDiscard),
    .rxPinOverride(rxPinOverride));
  rbf_reg_host i_rbf_reg_host(.clk_sys(clk_sys), .rst_n(rst_n),
    .clkEn(1'b1), .link(link.hostEnd), .cmdFetch(cmdFetch),
    .cmdFlush(cmdFlush), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr),
    .cmdData(cmdData), .globalIrqEn(globalIrqEn), .busy(busy),
    .fetchValid(fetchValid), .fetchData(fetchData), .fetchErr(fetchErr),
    .irqPending(irqPending));
  rbf_link_sva i_rbf_link_sva(.clk_sys(clk_sys), .rst_n(rst_n),
    .regAddr(link.regAddr), .regRd(link.regRd), .regWr(link.regWr),
    .regWdata(link.regWdata), .regRdata(link.regRdata),
    .regRvalid(link.regRvalid), .rxcIrq(link.rxcIrq));

  // Free-running clock, 20 ns period.
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Count discard pulses, since they stand for one cycle only.
  always @(posedge clk_sys)
    if (frameDiscard === 1'b1)
      discards++;

  // Every drive lands just after a rising edge.
  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic chk_val(input string what, input logic [8:0] expv,
    input logic [8:0] got);
    checked++;
    if (got !== expv)
    begin
      errTotal++;
      $display("mismatch %s expected %h seen %h", what, expv, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic expv,
    input logic got);
    checked++;
    if (got !== expv)
    begin
      errTotal++;
      $display("mismatch %s expected %b seen %b", what, expv, got);
    end
  endtask

  // Wait, bounded, until the host end is free again.
  task automatic wait_idle;
    int n;
    n = 0;
    tick;
    while (busy !== 1'b0 && n < 40)
    begin
      tick;
      n++;
    end
    repeat (2) tick;
  endtask

  // One finished frame from the shift register.
  task automatic send(input logic [8:0] d, input logic par, input logic stp);
    frameData = d;
    frameParity = par;
    frameStop = stp;
    frameValid = 1'b1;
    tick;
    frameValid = 1'b0;
    frameData = ~d;
    tick;
  endtask

  task automatic host_wr(input logic [1:0] a, input logic [7:0] d);
    cmdAddr = a;
    cmdData = d;
    cmdWrite = 1'b1;
    tick;
    cmdWrite = 1'b0;
    wait_idle;
  endtask

  // Fetch one character; the host reads status, control, then data.
  task automatic fetch_chk(input logic [8:0] d, input logic [2:0] e);
    int n;
    n = 0;
    cmdFetch = 1'b1;
    tick;
    cmdFetch = 1'b0;
    while (fetchValid !== 1'b1 && n < 40)
    begin
      tick;
      n++;
    end
    chk_bit("fetch done", 1'b1, fetchValid);
    chk_val("data", d, fetchData);
    chk_val("flags", {6'h00, e}, {6'h00, fetchErr});
    wait_idle;
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, errTotal);
    if (errTotal == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Cuts a hang short; the sequence needs well under a tenth of this.
  initial
  begin
    #400000;
    errTotal++;
    report_and_stop;
  end

  initial
  begin
    {rst_n, frameValid, frameParity, startDetect, frameData} = '0;
    {cmdFetch, cmdFlush, cmdWrite, cmdAddr, cmdData, globalIrqEn} = '0;
    frameStop = 1'b1;
    code = 3'h0;
    errTotal = 0;
    checked = 0;
    discards = 0;
    repeat (8) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    tick;
    host_wr(rbf_pkg::CONTROL_ADDR, 8'h90);
    chk_bit("pin", 1'b1, rxPinOverride);
    // Flags travel with their frames; request waits on the global enable.
    send(9'h05A, 1'b1, 1'b0);
    send(9'h0C3, 1'b1, 1'b1);
    repeat (4) tick;
    chk_bit("masked", 1'b0, irqPending);
    globalIrqEn = 1'b1;
    repeat (2) tick;
    chk_bit("request", 1'b1, irqPending);
    fetch_chk(9'h05A, 3'h4);
    fetch_chk(9'h0C3, 3'h0);
    repeat (3) tick;
    chk_bit("empty", 1'b0, irqPending);
    // Third frame waits in the slot; a new start makes an overrun.
    send(9'h011, 1'b1, 1'b1);
    send(9'h022, 1'b1, 1'b1);
    send(9'h033, 1'b1, 1'b1);
    startDetect = 1'b1;
    tick;
    startDetect = 1'b0;
    tick;
    fetch_chk(9'h011, 3'h0);
    fetch_chk(9'h022, 3'h0);
    fetch_chk(9'h033, 3'h2);
    send(9'h044, 1'b1, 1'b1);
    repeat (3) tick;
    fetch_chk(9'h044, 3'h0);
    // Flag ones offered for status go out as zeros; stored flags stay.
    send(9'h0A5, 1'b1, 1'b0);
    host_wr(rbf_pkg::STATUS_ADDR, 8'h1C);
    fetch_chk(9'h0A5, 3'h4);
    // Even then odd parity, each with a right and a wrong bit.
    for (int i = 0; i < 4; i++)
    begin
      host_wr(rbf_pkg::FORMAT_ADDR, (i < 2) ? 8'h26 : 8'h36);
      send(9'h001, ~i[0], 1'b1);
      repeat (3) tick;
      fetch_chk(9'h001, {2'b00, i[0] ^ i[1]});
    end
    // Size codes 0 to 3 and 7, two stop bits selected.
    for (int c = 0; c < 5; c++)
    begin
      code = (c == 4) ? 3'h7 : c[2:0];
      host_wr(rbf_pkg::CONTROL_ADDR, {5'b10010, code[2], 2'b00});
      host_wr(rbf_pkg::FORMAT_ADDR, {4'h0, 1'b1, code[1:0], 1'b0});
      send(9'h1FF, 1'b0, 1'b1);
      repeat (3) tick;
      fetch_chk((c == 4) ? 9'h1FF : (9'h001 << (c + 5)) - 9'h001,
        3'h0);
    end
    host_wr(rbf_pkg::FORMAT_ADDR, 8'h06);
    host_wr(rbf_pkg::CONTROL_ADDR, 8'h90);
    // Flush by the host, then by disabling the receiver.
    send(9'h055, 1'b1, 1'b1);
    send(9'h066, 1'b1, 1'b1);
    cmdFlush = 1'b1;
    tick;
    cmdFlush = 1'b0;
    wait_idle;
    chk_bit("flushed", 1'b0, irqPending);
    send(9'h077, 1'b1, 1'b1);
    host_wr(rbf_pkg::CONTROL_ADDR, 8'h80);
    chk_bit("pin off", 1'b0, rxPinOverride);
    chk_bit("disabled", 1'b0, irqPending);
    chk_val("discards", 9'h001, discards[8:0]);
    send(9'h088, 1'b1, 1'b1);
    host_wr(rbf_pkg::CONTROL_ADDR, 8'h90);
    fetch_chk(9'h000, 3'h0);
    report_and_stop;
  end
endmodule
